// *** verilog/csc_channel.sv ***
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "csc_params.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module csc_channel
#(
  parameter bit USE_READ_START = 1'b0  // set for the second channel
)
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // register port
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [3:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [3:0] reg_rdata_o,
  // start-transfer instruction strobe
  input  wire logic       start_transfer_instr_i,
  // serial pins
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe_n_o,
  input  wire logic       serial_in_pin_i,
  output logic            serial_out_pin_o,
  output logic            serial_out_pin_oe_n_o,
  // status
  output logic            irq_flag_o
);
  import csc_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0] mode_a_q, mode_a_d;
  logic [3:0] mode_a_eff_q, mode_a_eff_d;
  logic [1:0] mode_a_dly_q, mode_a_dly_d;
  logic [3:0] pin_fn_q, pin_fn_d;
  logic [3:0] out_drv_q, out_drv_d;
  logic       range_q, range_d;
  logic       idle_lvl_q, idle_lvl_d;
  logic [3:0] irq_reg_q, irq_reg_d;
  logic [3:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  csc_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic       sck_q, sck_d;
  logic       so_q, so_d;
  logic       first_low_q, first_low_d;

  // decoded strobes
  logic       wr_mode_a;
  logic       start_trig;
  logic       int_clk;
  logic       half_tick;
  logic       ext_level;
  logic       ext_rise;
  logic       ext_fall;
  logic       clk_rise;
  logic       clk_fall;
  logic       tx_en;
  logic       rx_en;

  assign wr_mode_a  = reg_wr_i && (reg_addr_i == `CSC_ADDR_MODE_A);
  // second channel starts on a dummy read of its mode A register
  assign start_trig = USE_READ_START ? (reg_rd_i && (reg_addr_i == `CSC_ADDR_MODE_A))
                                     : start_transfer_instr_i;
  assign int_clk    = mode_a_eff_q[`CSC_MODEA_INTCLK_BIT];
  // pin function low bits: 01 transmit, 10 receive, 11 both
  assign tx_en      = pin_fn_q[0];
  assign rx_en      = pin_fn_q[1];

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  csc_prescaler u_prescaler
  (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .rate_sel_i  ({range_q, mode_a_eff_q[2:0]}),
    .half_tick_o (half_tick)
  );

  csc_pin_sync u_sck_sync
  (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .pin_i     (serial_clock_pin_i),
    .level_o   (ext_level),
    .rise_o    (ext_rise),
    .fall_o    (ext_fall)
  );

  // external clock edges come through the synchroniser
  always_comb
  begin
    if (int_clk)
    begin
      clk_fall = half_tick && sck_q && (state_q != CSC_ST_START_WAIT);
      clk_rise = half_tick && !sck_q;
    end
    else
    begin
      clk_fall = ext_fall;
      clk_rise = ext_rise;
    end
  end

  // ----------------------------------------------------------------
  // register writes; mode A applies two cycles later
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_a_d     = mode_a_q;
    pin_fn_d     = pin_fn_q;
    out_drv_d    = out_drv_q;
    range_d      = range_q;
    idle_lvl_d   = idle_lvl_q;
    mode_a_dly_d = (mode_a_dly_q != 2'h0) ? mode_a_dly_q - 2'h1 : 2'h0;
    mode_a_eff_d = (mode_a_dly_q == 2'h1) ? mode_a_q : mode_a_eff_q;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CSC_ADDR_MODE_A:
        begin
          mode_a_d     = reg_wdata_i;
          mode_a_dly_d = `CSC_MODE_A_DELAY;
        end
        `CSC_ADDR_PIN_FN:    pin_fn_d  = reg_wdata_i;
        `CSC_ADDR_OUT_DRIVE: out_drv_d = reg_wdata_i;
        `CSC_ADDR_MODE_B:
        begin
          // mode B is locked while a frame is moving
          if (state_q != CSC_ST_TRANSFER)
          begin
            range_d    = reg_wdata_i[`CSC_MODEB_RANGE_BIT];
            idle_lvl_d = reg_wdata_i[`CSC_MODEB_IDLE_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // channel state machine, counter, shifter and clock pin
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    shreg_d     = shreg_q;
    sck_d       = sck_q;
    so_d        = so_q;
    first_low_d = first_low_q;
    irq_reg_d   = irq_reg_q;

    // software write of the flag register, then hardware set wins
    if (reg_wr_i && (reg_addr_i == `CSC_ADDR_IRQ_FLAGS))
      irq_reg_d = reg_wdata_i;
    if (reg_wr_i && (reg_addr_i == `CSC_ADDR_DATA_LO))
      shreg_d[3:0] = reg_wdata_i;
    if (reg_wr_i && (reg_addr_i == `CSC_ADDR_DATA_HI))
      shreg_d[7:4] = reg_wdata_i;

    case (state_q)
      CSC_ST_START_WAIT:
      begin
        // edges ignored, counter held clear
        cnt_d = 3'h0;
        sck_d = 1'b1;
        so_d  = idle_lvl_q;
        if (start_trig)
          state_d = CSC_ST_CLOCK_WAIT;
      end
      CSC_ST_CLOCK_WAIT:
      begin
        if (int_clk && half_tick)
          sck_d = ~sck_q;
        if (!tx_en || cnt_q == 3'h0)
          so_d = idle_lvl_q;
        if (wr_mode_a)
        begin
          state_d = CSC_ST_START_WAIT;
          cnt_d   = 3'h0;
          sck_d   = 1'b1;
        end
        else if (clk_fall)
        begin
          if (int_clk && pin_fn_q[1:0] == 2'b00)
            state_d = CSC_ST_CONT_CLOCK;
          else
          begin
            state_d     = CSC_ST_TRANSFER;
            first_low_d = 1'b1;
            if (tx_en)
              so_d = shreg_q[0];
          end
        end
      end
      CSC_ST_TRANSFER:
      begin
        if (int_clk && half_tick)
          sck_d = ~sck_q;
        if (clk_fall && tx_en)
          so_d = shreg_q[0];
        if (wr_mode_a || start_trig)
        begin
          cnt_d   = 3'h0;
          state_d = wr_mode_a ? CSC_ST_START_WAIT : CSC_ST_CLOCK_WAIT;
          sck_d   = 1'b1;
          // no flag during the first low pulse
          if (!first_low_q)
            irq_reg_d[`CSC_IRQ_FLAG_BIT] = 1'b1;
        end
        else if (clk_rise)
        begin
          first_low_d = 1'b0;
          shreg_d     = {(rx_en ? serial_in_pin_i : shreg_q[0]), shreg_q[7:1]};
          cnt_d       = cnt_q + 3'h1;
          if (cnt_q == 3'h7)
          begin
            // counter wraps; an extra noise pulse lands here early
            cnt_d = `CSC_BITS_PER_FRAME;
            irq_reg_d[`CSC_IRQ_FLAG_BIT] = 1'b1;
            state_d = int_clk ? CSC_ST_START_WAIT : CSC_ST_CLOCK_WAIT;
            sck_d   = 1'b1;  // clock stops after eight pulses
          end
        end
      end
      CSC_ST_CONT_CLOCK:
      begin
        if (half_tick)
          sck_d = ~sck_q;
        if (wr_mode_a)
        begin
          state_d = CSC_ST_START_WAIT;
          sck_d   = 1'b1;
        end
      end
      default:
        state_d = CSC_ST_START_WAIT;
    endcase

    // read data one cycle after the strobe
    rdata_d = 4'h0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `CSC_ADDR_IRQ_FLAGS: rdata_d = irq_reg_q;
        `CSC_ADDR_DATA_LO:   rdata_d = shreg_q[3:0];
        `CSC_ADDR_DATA_HI:   rdata_d = shreg_q[7:4];
        default:             rdata_d = 4'h0;  // write-only and unmapped read zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      mode_a_q     <= `CSC_RST_NIBBLE;
      mode_a_eff_q <= `CSC_RST_NIBBLE;
      mode_a_dly_q <= 2'h0;
      pin_fn_q     <= `CSC_RST_NIBBLE;
      out_drv_q    <= `CSC_RST_NIBBLE;
      range_q      <= 1'b0;
      idle_lvl_q   <= `CSC_RST_IDLE_LEVEL;
      irq_reg_q    <= `CSC_RST_NIBBLE;
      rdata_q      <= 4'h0;
      state_q      <= CSC_ST_START_WAIT;
      cnt_q        <= 3'h0;
      shreg_q      <= 8'h00;
      sck_q        <= 1'b1;
      so_q         <= `CSC_RST_IDLE_LEVEL;
      first_low_q  <= 1'b0;
    end
    else
    begin
      mode_a_q     <= mode_a_d;
      mode_a_eff_q <= mode_a_eff_d;
      mode_a_dly_q <= mode_a_dly_d;
      pin_fn_q     <= pin_fn_d;
      out_drv_q    <= out_drv_d;
      range_q      <= range_d;
      idle_lvl_q   <= idle_lvl_d;
      irq_reg_q    <= irq_reg_d;
      rdata_q      <= rdata_d;
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      shreg_q      <= shreg_d;
      sck_q        <= sck_d;
      so_q         <= so_d;
      first_low_q  <= first_low_d;
    end
  end

  // pin enables are low-active; clock driven only in internal mode
  logic sck_oe_n_q;
  logic so_oe_n_q;
  logic irq_q;
  logic unused_lvl;
  assign unused_lvl = ext_level ^ out_drv_q[0];

  // output enables, kept in flops so every port leaves a register
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      sck_oe_n_q <= 1'b1;
      so_oe_n_q  <= 1'b1;
      irq_q      <= 1'b0;
    end
    else
    begin
      sck_oe_n_q <= ~mode_a_eff_d[`CSC_MODEA_INTCLK_BIT];
      so_oe_n_q  <= ~pin_fn_d[0];
      irq_q      <= irq_reg_d[`CSC_IRQ_FLAG_BIT];
    end
  end

  assign reg_rdata_o             = rdata_q;
  assign serial_clock_pin_o      = sck_q;
  assign serial_clock_pin_oe_n_o = sck_oe_n_q;
  assign serial_out_pin_o        = so_q;
  assign serial_out_pin_oe_n_o   = so_oe_n_q;
  assign irq_flag_o              = irq_q;
endmodule : csc_channel

// *** include/csc_params.svh ***
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// register addresses
`define CSC_ADDR_IRQ_FLAGS   6'h03
`define CSC_ADDR_PIN_FN      6'h04
`define CSC_ADDR_MODE_A      6'h05
`define CSC_ADDR_DATA_LO     6'h06
`define CSC_ADDR_DATA_HI     6'h07
`define CSC_ADDR_OUT_DRIVE   6'h0C
`define CSC_ADDR_MODE_B      6'h28
// field positions
`define CSC_IRQ_FLAG_BIT     2
`define CSC_MODEA_INTCLK_BIT 3
`define CSC_MODEB_RANGE_BIT  0
`define CSC_MODEB_IDLE_BIT   1
// reset values
`define CSC_RST_NIBBLE       4'h0
`define CSC_RST_IDLE_LEVEL   1'b1
// timing counts
`define CSC_MODE_A_DELAY     2'h2
`define CSC_BITS_PER_FRAME   3'h0
// prescaler half periods less one, by rate select {range, rate}
`define CSC_HALF_SEL_0       12'h7FF
`define CSC_HALF_SEL_1       12'h1FF
`define CSC_HALF_SEL_2       12'h07F
`define CSC_HALF_SEL_3       12'h01F
`define CSC_HALF_SEL_4       12'h007
`define CSC_HALF_SEL_5       12'h001
`define CSC_HALF_SEL_8       12'hFFF
`define CSC_HALF_SEL_9       12'h3FF
`define CSC_HALF_SEL_A       12'h0FF
`define CSC_HALF_SEL_B       12'h03F
`define CSC_HALF_SEL_C       12'h00F
`define CSC_HALF_SEL_D       12'h003

`endif

// *** include/csc_pkg.sv ***
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_ST_START_WAIT = 2'b00,
    CSC_ST_CLOCK_WAIT = 2'b01,
    CSC_ST_TRANSFER   = 2'b10,
    CSC_ST_CONT_CLOCK = 2'b11
  } csc_state_t;
endpackage : csc_pkg

// *** verilog/csc_prescaler.sv ***
`timescale 1ns/10ps
`include "csc_params.svh"
// ----------------------------------------------------------------
// free-running prescaler giving a one-cycle tick per half period
// ----------------------------------------------------------------
module csc_prescaler
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // rate select {range, rate[2:0]}
  input  wire logic [3:0] rate_sel_i,
  // half-period tick
  output logic            half_tick_o
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [11:0] half_len;
  logic        tick_d;
  logic        tick_q;

  // half of the transmit clock period, less one
  always_comb
  begin
    case (rate_sel_i)
      4'h0:    half_len = `CSC_HALF_SEL_0;  // 4096 cycles
      4'h1:    half_len = `CSC_HALF_SEL_1;  // 1024
      4'h2:    half_len = `CSC_HALF_SEL_2;  // 256
      4'h3:    half_len = `CSC_HALF_SEL_3;  // 64
      4'h4:    half_len = `CSC_HALF_SEL_4;  // 16
      4'h5:    half_len = `CSC_HALF_SEL_5;  // 4
      4'h8:    half_len = `CSC_HALF_SEL_8;  // 8192
      4'h9:    half_len = `CSC_HALF_SEL_9;  // 2048
      4'hA:    half_len = `CSC_HALF_SEL_A;  // 512
      4'hB:    half_len = `CSC_HALF_SEL_B;  // 128
      4'hC:    half_len = `CSC_HALF_SEL_C;  // 32
      4'hD:    half_len = `CSC_HALF_SEL_D;  // 8
      default: half_len = 12'h001;  // unlisted codes fall back to fastest
    endcase
    tick_d = (cnt_q >= half_len);
    cnt_d  = tick_d ? 12'h000 : cnt_q + 12'h001;
  end

  // counter register
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      cnt_q  <= 12'h000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign half_tick_o = tick_q;
endmodule : csc_prescaler

// *** verilog/csc_pin_sync.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module csc_pin_sync
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  // raw pin
  input  wire logic pin_i,
  // filtered level, rise and fall pulses
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       lvl_q;
  logic       lvl_d;

  // a change counts only when the last two stages agree
  always_comb
  begin
    sync_d = {sync_q[1:0], pin_i};
    lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
  end

  // pins idle high, so reset to one to avoid a false edge
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      sync_q <= 3'b111;
      lvl_q  <= 1'b1;
    end
    else
    begin
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
    end
  end

  assign level_o = lvl_q;
  assign rise_o  = lvl_d & ~lvl_q;
  assign fall_o  = ~lvl_d & lvl_q;
endmodule : csc_pin_sync

// *** verif/csc_channel_props.sv ***
`timescale 1ns/10ps
`include "csc_params.svh"
// --------
// port checks for one serial channel
// --------
module csc_channel_props
#(
  parameter bit READ_START = 1'b0  // trigger is a mode A read, as in the second channel
)
(
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       srst_i,
  // register port
  input wire logic [5:0] reg_addr_i,
  input wire logic [3:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  // trigger, pins and status
  input wire logic       start_transfer_instr_i,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe_n_o,
  input wire logic       serial_out_pin_o,
  input wire logic       serial_out_pin_oe_n_o,
  input wire logic       irq_flag_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic       mode_a_wr, pf_wr, flag_wr, sck_q, started_q, started_d, trig;
  logic [1:0] pf_q, pf_d;
  logic [3:0] falls_q, falls_d;
  // decoded writes
  assign mode_a_wr = reg_wr_i && (reg_addr_i == `CSC_ADDR_MODE_A);
  assign pf_wr     = reg_wr_i && (reg_addr_i == `CSC_ADDR_PIN_FN);
  assign flag_wr   = reg_wr_i && (reg_addr_i == `CSC_ADDR_IRQ_FLAGS);
  // the start trigger of this channel
  assign trig      = READ_START ? (reg_rd_i && (reg_addr_i == `CSC_ADDR_MODE_A))
                                : start_transfer_instr_i;
  // driven clock falls since the last trigger or mode A write; saturates so it never wraps back to legal
  always_comb
  begin
    pf_d      = pf_wr ? reg_wdata_i[1:0] : pf_q;
    started_d = started_q | trig;
    falls_d   = falls_q;
    if (trig || mode_a_wr)
      falls_d = 4'h0;
    else if (sck_q && !serial_clock_pin_o && !serial_clock_pin_oe_n_o && falls_q != 4'hF)
      falls_d = falls_q + 4'h1;
  end
  // helper registers
  always_ff @(posedge ref_clk_i)
  begin
    sck_q     <= srst_i | serial_clock_pin_o;
    pf_q      <= srst_i ? 2'h0 : pf_d;
    started_q <= srst_i ? 1'b0 : started_d;
    falls_q   <= srst_i ? 4'h0 : falls_d;
  end
  // a write followed by two quiet cycles
  sequence s_mode_a_quiet;
    mode_a_wr ##1 !mode_a_wr [*2];
  endsequence
  sequence s_pf_quiet;
    pf_wr ##1 !pf_wr [*2];
  endsequence
  reset_state_a: assert property ($fell(srst_i) |-> serial_clock_pin_o && serial_out_pin_o
    && serial_clock_pin_oe_n_o && serial_out_pin_oe_n_o && !irq_flag_o)
    else $error("pins not idle after reset");
  no_trig_flag_a: assert property (!started_q |-> !$rose(irq_flag_o)
    || $past(flag_wr) || $past(flag_wr, 2)) else $error("flag set before any trigger");
  flag_clear_a: assert property ($fell(irq_flag_o) |-> $past(flag_wr) || $past(flag_wr, 2))
    else $error("flag dropped without a flag write");
  clk_oe_lag_a: assert property (s_mode_a_quiet |=>
    serial_clock_pin_oe_n_o == !$past(reg_wdata_i[3], 3)) else $error("clock drive wrong");
  out_oe_sel_a: assert property (s_pf_quiet |=>
    serial_out_pin_oe_n_o == !$past(reg_wdata_i[0], 3)) else $error("data drive wrong");
  pulse_limit_a: assert property (pf_q != 2'h0 |-> falls_q <= 4'h8)
    else $error("more than eight clocks driven");
  cont_no_flag_a: assert property (pf_q == 2'h0 && !serial_clock_pin_oe_n_o
    |-> !$rose(irq_flag_o)) else $error("flag in continuous clock");
  clk_stop_high_a: assert property ($rose(irq_flag_o) && !serial_clock_pin_oe_n_o
    |-> ##2 serial_clock_pin_o [*8]) else $error("clock not stopped high");
  modea_idle_a: assert property (mode_a_wr |-> ##2 serial_clock_pin_o [*2])
    else $error("clock active after mode write");
endmodule : csc_channel_props

// *** verif/csc_serial_peer.sv ***
`timescale 1ns/10ps
// --------
// far-side serial device: makes the clock in external mode, shifts both ways
// --------
module csc_serial_peer
(
  // control from the bench
  input  wire logic       ref_clk_i,
  input  wire logic       load_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic [4:0] edges_i,
  // serial lines
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  output logic            ext_clk_o,
  output logic            sdi_o,
  // status
  output logic [7:0]      rx_byte_o,
  output logic            busy_o
);
  localparam int HALF = 12;  // half period of its own clock, slow enough for the synchroniser
  logic [7:0] tx_q;
  logic [2:0] idx_q;
  logic [4:0] left_q;
  logic [4:0] cnt_q;
  logic       sck_q;
  // idle clock starts high, so the first frame opens with a fall
  initial
  begin
    ext_clk_o = 1'b1;
    sdi_o     = 1'b0;
    rx_byte_o = 8'h00;
    left_q    = 5'h00;
    sck_q     = 1'b1;
  end
  assign busy_o = (left_q != 5'h00);
  // clock maker; an odd edge count leaves the line low on purpose
  always @(posedge ref_clk_i)
  begin
    sck_q <= sck_i;
    if (load_i)
    begin
      tx_q   <= tx_byte_i;
      idx_q  <= 3'h0;
      left_q <= edges_i;
      cnt_q  <= 5'h00;
    end
    else if (left_q != 5'h00)
    begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == 5'(HALF - 1))
      begin
        ext_clk_o <= ~ext_clk_o;
        left_q    <= left_q - 5'h01;
        cnt_q     <= 5'h00;
      end
    end
    // out on the fall and in on the rise, lowest bit first
    if (sck_q && !sck_i)
    begin
      sdi_o <= tx_q[idx_q];
      idx_q <= idx_q + 3'h1;
    end
    if (!sck_q && sck_i)
      rx_byte_o <= {sdo_i, rx_byte_o[7:1]};
  end
endmodule : csc_serial_peer

// *** verif/tb.sv ***
`timescale 1ns/10ps
`include "csc_params.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
// --------
// bench top: one channel with the far-side device on its pins, plus a read-started second channel
// --------
module tb;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [3:0] wdata = 4'h0, d;
  logic wr_i = 1'b0, rd_i = 1'b0, st = 1'b0, p_load = 1'b0, sck_q = 1'b1;
  logic [7:0] p_tx = 8'h00;
  logic [4:0] p_edges = 5'h00;
  wire [3:0] rdata;
  wire [7:0] p_rx;
  wire sck_o, sck_oe_n, sdo, sdo_oe_n, irq, irq2, sck, ext_clk, sdi, p_busy;
  int cyc, miscompares, total_checks, falls, last_fall, period;
  logic [3:0] sel_tab [3] = '{4'hD, 4'h4, 4'hC};
  int per_tab [3] = '{8, 16, 32};
  // clock pin level seen by both parties
  assign sck = sck_oe_n ? ext_clk : sck_o;
  always #12.5 ref_clk_i = ~ref_clk_i;
  csc_channel dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_i), .reg_rd_i(rd_i), .reg_rdata_o(rdata),
    .start_transfer_instr_i(st), .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_n_o(sck_oe_n), .serial_in_pin_i(sdi), .serial_out_pin_o(sdo),
    .serial_out_pin_oe_n_o(sdo_oe_n), .irq_flag_o(irq));
  csc_serial_peer peer (.ref_clk_i(ref_clk_i), .load_i(p_load), .tx_byte_i(p_tx),
    .edges_i(p_edges), .sck_i(sck), .sdo_i(sdo), .ext_clk_o(ext_clk), .sdi_o(sdi),
    .rx_byte_o(p_rx), .busy_o(p_busy));
  // second channel: same bus, started only by a read of its mode A register
  csc_channel #(.USE_READ_START(1'b1)) dut2 (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_i), .reg_rd_i(rd_i), .reg_rdata_o(),
    .start_transfer_instr_i(st), .serial_clock_pin_i(sck), .serial_clock_pin_o(),
    .serial_clock_pin_oe_n_o(), .serial_in_pin_i(sdi), .serial_out_pin_o(),
    .serial_out_pin_oe_n_o(), .irq_flag_o(irq2));
  // falls on the clock line, last period, and the hang limit
  always @(posedge ref_clk_i)
  begin
    cyc++;
    sck_q <= sck;
    if (sck_q && !sck)
    begin
      falls++;
      period = cyc - last_fall;
      last_fall = cyc;
    end
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task tick(); @(posedge ref_clk_i); #1; endtask : tick
  task wr(input logic [5:0] a, input logic [3:0] v);
    @(posedge ref_clk_i); addr <= a; wdata <= v; wr_i <= 1'b1;
    @(posedge ref_clk_i); wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [5:0] a);
    @(posedge ref_clk_i); addr <= a; rd_i <= 1'b1;
    @(posedge ref_clk_i); rd_i <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task start(); @(posedge ref_clk_i); st <= 1'b1; @(posedge ref_clk_i); st <= 1'b0; endtask : start
  task peer_go(input logic [7:0] tx, input logic [4:0] e);
    @(posedge ref_clk_i); p_tx <= tx; p_edges <= e; p_load <= 1'b1;
    @(posedge ref_clk_i); p_load <= 1'b0;
  endtask : peer_go
  task wait_irq(); for (int n = 0; n < 4000 && irq !== 1'b1; n++) tick(); endtask : wait_irq
  task wait_peer(); tick(); for (int n = 0; n < 4000 && p_busy; n++) tick(); endtask : wait_peer
  // reset values, empty reads, clocks ignored before a trigger
  task t_reset();
    `CHK("clock pin", 1'b1, sck_o)
    `CHK("irq", 1'b0, irq)
    rd(`CSC_ADDR_IRQ_FLAGS); `CHK("flags", 4'h0, d)
    rd(`CSC_ADDR_MODE_A); `CHK("mode a read", 4'h0, d)
    rd(6'h10); `CHK("unmapped", 4'h0, d)
    peer_go(8'h00, 5'd16); wait_peer(); repeat (6) tick();
    `CHK("ignored clocks", 1'b0, irq)
    `CHK("read start", 1'b1, irq2)
  endtask : t_reset
  // idle output level follows the mode b bit
  task t_idle();
    wr(`CSC_ADDR_MODE_B, 4'h0); tick(); `CHK("idle low", 1'b0, sdo)
    wr(`CSC_ADDR_MODE_B, 4'h2); tick(); `CHK("idle high", 1'b1, sdo)
    wr(`CSC_ADDR_PIN_FN, 4'h2); tick(); `CHK("rx only drive", 1'b1, sdo_oe_n)
    wr(`CSC_ADDR_PIN_FN, 4'h1); tick(); `CHK("tx only drive", 1'b0, sdo_oe_n)
  endtask : t_idle
  // internal clock frames at three rates, both directions
  task t_int();
    wr(`CSC_ADDR_PIN_FN, 4'h3);
    for (int i = 0; i < 3; i++)
    begin
      wr(`CSC_ADDR_MODE_B, {3'b001, sel_tab[i][3]});
      wr(`CSC_ADDR_MODE_A, {1'b1, sel_tab[i][2:0]});
      wr(`CSC_ADDR_DATA_LO, 4'h5); wr(`CSC_ADDR_DATA_HI, 4'hA);
      peer_go(8'h3C, 5'd0); falls = 0;
      start(); wait_irq(); repeat (4) tick();
      `CHK("frame irq", 1'b1, irq)
      `CHK("pulses", 8, falls)
      `CHK("period", per_tab[i], period)
      `CHK("sent byte", 8'hA5, p_rx)
      rd(`CSC_ADDR_DATA_LO); `CHK("rx low", 4'hC, d)
      rd(`CSC_ADDR_DATA_HI); `CHK("rx high", 4'h3, d)
      rd(`CSC_ADDR_IRQ_FLAGS); `CHK("flag bit", 4'h4, d)
      wr(`CSC_ADDR_IRQ_FLAGS, 4'h0);
    end
  endtask : t_int
  // continuous clock, then stopped by a mode a write
  task t_cont();
    wr(`CSC_ADDR_PIN_FN, 4'h0); wr(`CSC_ADDR_MODE_A, 4'hD);
    falls = 0; start(); repeat (80) tick();
    `CHK("free clock", 1'b1, falls > 8)
    `CHK("no flag", 1'b0, irq)
    wr(`CSC_ADDR_MODE_A, 4'h8); repeat (2) tick(); falls = 0; repeat (40) tick();
    `CHK("stopped", 0, falls)
    `CHK("clock high", 1'b1, sck_o)
  endtask : t_cont
  // external clock frame, then a second frame with no new trigger
  task t_ext();
    wr(`CSC_ADDR_PIN_FN, 4'h3); wr(`CSC_ADDR_MODE_A, 4'h0);
    wr(`CSC_ADDR_DATA_LO, 4'h6); wr(`CSC_ADDR_DATA_HI, 4'h9);
    start(); peer_go(8'h5A, 5'd16); wait_irq(); wait_peer();
    `CHK("ext irq", 1'b1, irq)
    `CHK("ext sent", 8'h96, p_rx)
    rd(`CSC_ADDR_DATA_LO); `CHK("ext rx low", 4'hA, d)
    rd(`CSC_ADDR_DATA_HI); `CHK("ext rx high", 4'h5, d)
    wr(`CSC_ADDR_IRQ_FLAGS, 4'h0); peer_go(8'h00, 5'd16); wait_irq();
    `CHK("rearmed", 1'b1, irq)
    wr(`CSC_ADDR_IRQ_FLAGS, 4'h0); wr(`CSC_ADDR_MODE_A, 4'h0); repeat (3) tick();
  endtask : t_ext
  // nine pulses: early wrap, then a mode a write flags again
  task t_spur();
    start(); peer_go(8'h00, 5'd18); wait_peer(); repeat (8) tick();
    `CHK("spurious flag", 1'b1, irq)
    wr(`CSC_ADDR_IRQ_FLAGS, 4'h0); repeat (2) tick();
    wr(`CSC_ADDR_MODE_A, 4'h0); repeat (3) tick();
    `CHK("flag again", 1'b1, irq)
    wr(`CSC_ADDR_IRQ_FLAGS, 4'h0);
  endtask : t_spur
  // abort with the pin high, then abort in the first low pulse
  task t_abort();
    start(); peer_go(8'h00, 5'd6); wait_peer(); repeat (8) tick();
    `CHK("mid frame", 1'b0, irq)
    wr(`CSC_ADDR_MODE_B, 4'h0); // refused while a frame moves
    start(); repeat (3) tick();
    `CHK("abort flag", 1'b1, irq)
    `CHK("mode b locked", 1'b1, sdo)
    wr(`CSC_ADDR_IRQ_FLAGS, 4'h0); falls = 0; peer_go(8'h00, 5'd16); wait_irq();
    `CHK("recount", 8, falls)
    `CHK("clock wait", 1'b1, irq)
    wr(`CSC_ADDR_IRQ_FLAGS, 4'h0); wr(`CSC_ADDR_MODE_A, 4'h0); repeat (2) tick();
    start(); peer_go(8'h00, 5'd1); wait_peer(); repeat (6) tick();
    wr(`CSC_ADDR_MODE_A, 4'h0); repeat (4) tick();
    `CHK("first low abort", 1'b0, irq)
    peer_go(8'h00, 5'd1); wait_peer(); repeat (6) tick();
    `CHK("start wait", 1'b0, irq)
  endtask : t_abort
  task test_done();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    tick();
    t_reset(); t_idle(); t_int(); t_cont(); t_ext(); t_spur(); t_abort();
    test_done();
  end
endmodule : tb
bind csc_channel csc_channel_props #(.READ_START(USE_READ_START)) u_props (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .start_transfer_instr_i(start_transfer_instr_i), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o), .irq_flag_o(irq_flag_o));
